// ===== rtl/monitor_alarm_warning_status.sv
// Read-only alarm and warning status bank for the module controller.
`timescale 1ns/1ps
module monitor_alarm_warning_status (
    input  wire logic                                clk_sys,
    input  wire logic                                rst,
    input  wire logic                                tx_disable_event,
    input  wire logic                                bias_cmp_valid,
    input  wire logic                                bias_above_threshold,
    input  wire logic                                txp_cmp_valid,
    input  wire logic                                txp_above_high,
    input  wire logic                                txp_below_low,
    input  wire logic                                third_monitor_input_cmp_valid,
    input  wire logic                                third_monitor_input_above_upper,
    input  wire logic                                third_monitor_input_below_lower,
    input  wire logic                                bias_req_valid,
    input  wire logic [alarm_status_pkg::BIAS_W-1:0] bias_request,
    input  wire logic [alarm_status_pkg::BIAS_W-1:0] bias_ceiling_setting,
    input  wire logic [3:0]                          meas_valid,
    input  wire logic [3:0]                          meas_above_high,
    input  wire logic [3:0]                          meas_below_low,
    input  wire logic                                supply_below_poa_trip,
    input  wire logic [7:0]                          warn_enable,
    input  wire logic [7:0]                          loss_enable,
    input  wire logic [7:0]                          shutdown_enable,
    input  wire logic                                reg_rd_en,
    input  wire logic [7:0]                          reg_addr,
    output logic      [7:0]                          reg_rd_data,
    output logic                                     reg_rd_hit,
    output logic                                     transmit_fault_interrupt,
    output logic                                     laser_shutdown_gate
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic alarm_status_pkg::reg_sel_e decode_addr(input logic [7:0] addr);
        if (addr == alarm_status_pkg::FAST_ALARM_OFS) begin
            decode_addr = alarm_status_pkg::SEL_FAST;
        end else if (addr == alarm_status_pkg::LOSS_ALARM_OFS) begin
            decode_addr = alarm_status_pkg::SEL_LOSS;
        end else if (addr == alarm_status_pkg::WARN_OFS) begin
            decode_addr = alarm_status_pkg::SEL_WARN;
        end else begin
            decode_addr = alarm_status_pkg::SEL_NONE;
        end
    endfunction

    logic [7:0] fast_q;
    logic [7:0] fast_d;
    logic       bias_ceil_q;
    logic       bias_ceil_d;
    logic [7:0] warn_q;
    logic [7:0] warn_d;
    logic [7:0] loss_reg;
    logic [7:0] rd_data_d;
    logic       rd_hit_d;
    logic       fault_d;
    logic       shutdown_d;

    loss_if lif ();

    assign lif.third_monitor_input_valid  = third_monitor_input_cmp_valid;
    assign lif.above_upper = third_monitor_input_above_upper;
    assign lif.below_lower = third_monitor_input_below_lower;

    loss_hysteresis u_loss (
        .clk_sys (clk_sys),
        .rst     (rst),
        .lif     (lif.owner)
    );

    // ****************************************************************
    // Fast alarms and bias ceiling
    // ****************************************************************
    // A fresh comparison in the same cycle as a transmit-disable wins, so
    // a fault that is still present is never hidden by the disable.
    always_comb begin
        fast_d      = fast_q;
        bias_ceil_d = bias_ceil_q;
        if (bias_cmp_valid) begin
            fast_d[alarm_status_pkg::HIGH_BIAS_BIT] = bias_above_threshold;
        end else if (tx_disable_event) begin
            fast_d[alarm_status_pkg::HIGH_BIAS_BIT] = 1'b0;
        end
        if (txp_cmp_valid) begin
            fast_d[alarm_status_pkg::TX_POWER_HI_BIT] = txp_above_high;
            fast_d[alarm_status_pkg::TX_POWER_LO_BIT] = txp_below_low;
        end else if (tx_disable_event) begin
            fast_d[alarm_status_pkg::TX_POWER_HI_BIT] = 1'b0;
            fast_d[alarm_status_pkg::TX_POWER_LO_BIT] = 1'b0;
        end
        if (bias_req_valid) begin
            bias_ceil_d = bias_request > bias_ceiling_setting;
        end else if (tx_disable_event) begin
            bias_ceil_d = 1'b0;
        end
        fast_d = fast_d & alarm_status_pkg::FAST_ALARM_MASK;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fast_q      <= alarm_status_pkg::FAST_ALARM_RST;
            bias_ceil_q <= 1'b0;
        end else begin
            fast_q      <= fast_d;
            bias_ceil_q <= bias_ceil_d;
        end
    end

    // ****************************************************************
    // Measurement warnings
    // ****************************************************************
    // Channel i owns bit 7-2i for its high warning and bit 6-2i for its low.
    generate
        for (genvar i = 0; i < alarm_status_pkg::WARN_CHANNELS; i++) begin : g_warn
            localparam int HI = alarm_status_pkg::WARN_TOP_BIT - 2 * i;
            localparam int LO = HI - 1;
            always_comb begin
                warn_d[HI] = warn_q[HI];
                warn_d[LO] = warn_q[LO];
                if (meas_valid[i]) begin
                    warn_d[HI] = meas_above_high[i];
                end
                if (i == alarm_status_pkg::SUPPLY_CH) begin
                    // The supply flag must stay up while the rail is too low to trust.
                    if (supply_below_poa_trip) begin
                        warn_d[LO] = 1'b1;
                    end else if (meas_valid[i]) begin
                        warn_d[LO] = meas_below_low[i];
                    end
                end else if (meas_valid[i]) begin
                    warn_d[LO] = meas_below_low[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            warn_q <= alarm_status_pkg::WARN_RST;
        end else begin
            warn_q <= warn_d;
        end
    end

    // ****************************************************************
    // Register read port and fault outputs
    // ****************************************************************
    always_comb begin
        loss_reg = alarm_status_pkg::READ_ZERO;
        loss_reg[alarm_status_pkg::RX_LOSS_HI_BIT]   = lif.high_flag;
        loss_reg[alarm_status_pkg::RX_LOSS_LO_BIT]   = lif.low_flag;
        loss_reg[alarm_status_pkg::BIAS_CEILING_BIT] = bias_ceil_q;
    end

    always_comb begin
        rd_data_d = reg_rd_data;
        rd_hit_d  = 1'b0;
        if (reg_rd_en) begin
            rd_hit_d = 1'b1;
            case (decode_addr(reg_addr))
                alarm_status_pkg::SEL_FAST: rd_data_d = fast_q;
                alarm_status_pkg::SEL_LOSS: rd_data_d = loss_reg;
                alarm_status_pkg::SEL_WARN: rd_data_d = warn_q;
                default: begin
                    rd_data_d = alarm_status_pkg::READ_ZERO;
                    rd_hit_d  = 1'b0;
                end
            endcase
        end
        fault_d = (|(warn_q & warn_enable))
                | (|(loss_reg & loss_enable & alarm_status_pkg::LOSS_MASKABLE))
                | (|(loss_reg & alarm_status_pkg::LOSS_NONMASK))
                | (|fast_q);
        shutdown_d = |(fast_q & shutdown_enable & alarm_status_pkg::FAST_ALARM_MASK);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rd_data              <= alarm_status_pkg::READ_ZERO;
            reg_rd_hit               <= 1'b0;
            transmit_fault_interrupt <= 1'b0;
            laser_shutdown_gate      <= 1'b0;
        end else begin
            reg_rd_data              <= rd_data_d;
            reg_rd_hit               <= rd_hit_d;
            transmit_fault_interrupt <= fault_d;
            laser_shutdown_gate      <= shutdown_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_read_fast;
        reg_rd_en && reg_addr == alarm_status_pkg::FAST_ALARM_OFS;
    endsequence

    sequence s_read_warn;
        reg_rd_en && reg_addr == alarm_status_pkg::WARN_OFS;
    endsequence

    sequence s_read_loss;
        reg_rd_en && reg_addr == alarm_status_pkg::LOSS_ALARM_OFS;
    endsequence

    AST_HIGH_BIAS_FAST_ALARM_TRACK: assert property (
        bias_cmp_valid |=> fast_q[3] == $past(bias_above_threshold)
    ) else $error("high bias alarm did not follow comparison");

    AST_TX_POWER_HIGH_ALARM_TRACK: assert property (
        txp_cmp_valid |=> fast_q[1] == $past(txp_above_high)
    ) else $error("tx power high alarm did not follow comparison");

    AST_TXD_CLEARS: assert property (
        tx_disable_event && !txp_cmp_valid && !bias_cmp_valid |=> fast_q == 8'h00
    ) else $error("transmit disable did not clear fast alarms");

    AST_BIAS_CEIL: assert property (
        bias_req_valid |=> bias_ceil_q == ($past(bias_request) > $past(bias_ceiling_setting))
    ) else $error("bias ceiling flag wrong");

    AST_WARN_TEMP: assert property (
        meas_valid[0] |=> warn_q[7] == $past(meas_above_high[0])
                          && warn_q[6] == $past(meas_below_low[0])
    ) else $error("temperature warnings did not follow measurement");

    AST_SUPPLY_LOW: assert property (
        supply_below_poa_trip |=> warn_q[4] ##1 (warn_q[4] || $past(meas_valid[1]))
    ) else $error("supply low warning not held while below trip");

    AST_READ_FAST: assert property (
        s_read_fast |=> reg_rd_hit && reg_rd_data == $past(fast_q) && reg_rd_data[7:4] == 4'h0
    ) else $error("fast alarm read wrong or reserved bits set");

    AST_READ_WARN: assert property (
        s_read_warn |=> reg_rd_data == $past(warn_q)
    ) else $error("warning register read wrong");

    AST_UNMAPPED: assert property (
        reg_rd_en && decode_addr(reg_addr) == alarm_status_pkg::SEL_NONE
        |=> !reg_rd_hit && reg_rd_data == 8'h00
    ) else $error("unmapped read not answered with zero");

    AST_FAULT_NONMASK: assert property (
        (|fast_q) || bias_ceil_q |=> transmit_fault_interrupt
    ) else $error("nonmaskable alarm did not raise fault interrupt");

    AST_SHUTDOWN: assert property (
        ##1 laser_shutdown_gate == |($past(fast_q) & $past(shutdown_enable) & 8'h0b)
    ) else $error("laser shutdown gate mismatch");

    AST_TX_POWER_LOW_ALARM_TRACK: assert property (
        txp_cmp_valid |=> fast_q[0] == $past(txp_below_low)
    ) else $error("tx power low alarm did not follow comparison");

    AST_CEIL_TXD_CLEARS: assert property (
        tx_disable_event && !bias_req_valid |=> !bias_ceil_q
    ) else $error("transmit disable did not clear bias ceiling flag");

    AST_WARN_SUPPLY_HI: assert property (
        meas_valid[1] |=> warn_q[5] == $past(meas_above_high[1])
    ) else $error("supply high warning did not follow measurement");

    AST_WARN_FIRST_MONITOR_INPUT: assert property (
        meas_valid[2] |=> warn_q[3] == $past(meas_above_high[2])
                          && warn_q[2] == $past(meas_below_low[2])
    ) else $error("first monitor warnings did not follow measurement");

    AST_WARN_SECOND_MONITOR_INPUT: assert property (
        meas_valid[3] |=> warn_q[1] == $past(meas_above_high[3])
                          && warn_q[0] == $past(meas_below_low[3])
    ) else $error("second monitor warnings did not follow measurement");

    AST_SUPPLY_CLEAR: assert property (
        meas_valid[1] && !supply_below_poa_trip |=> warn_q[4] == $past(meas_below_low[1])
    ) else $error("supply low warning did not follow a completed measurement");

    AST_READ_LOSS: assert property (
        s_read_loss |=> reg_rd_hit && reg_rd_data == $past(loss_reg)
                        && (reg_rd_data & ~alarm_status_pkg::LOSS_ALARM_MASK) == 8'h00
    ) else $error("loss alarm read wrong or reserved bits set");

    AST_HIT_PULSE: assert property (
        !reg_rd_en |=> !reg_rd_hit
    ) else $error("read hit raised without a read request");

endmodule

// ===== rtl/alarm_status_pkg.sv
// Constants and types shared by the monitor alarm and warning status block.
package alarm_status_pkg;

    // ****************************************************************
    // Register offsets and values after reset
    // ****************************************************************
    localparam logic [7:0] FAST_ALARM_OFS = 8'h72;
    localparam logic [7:0] LOSS_ALARM_OFS = 8'h73;
    localparam logic [7:0] WARN_OFS       = 8'h74;

    localparam logic [7:0] FAST_ALARM_RST = 8'h00;
    localparam logic [7:0] LOSS_ALARM_RST = 8'h00;
    localparam logic [7:0] WARN_RST       = 8'h10;
    localparam logic [7:0] READ_ZERO      = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int HIGH_BIAS_BIT    = 3;
    localparam int TX_POWER_HI_BIT  = 1;
    localparam int TX_POWER_LO_BIT  = 0;
    localparam int RX_LOSS_HI_BIT   = 7;
    localparam int RX_LOSS_LO_BIT   = 6;
    localparam int BIAS_CEILING_BIT = 3;

    // Warning channels: temperature, supply, first and second monitor.
    localparam int WARN_CHANNELS    = 4;
    localparam int WARN_TOP_BIT     = 7;
    localparam int SUPPLY_CH        = 1;
    localparam int SUPPLY_LO_BIT    = 4;

    // Implemented bits; every other position reads as zero.
    localparam logic [7:0] FAST_ALARM_MASK = 8'h0b;
    localparam logic [7:0] LOSS_ALARM_MASK = 8'hc8;
    localparam logic [7:0] LOSS_MASKABLE   = 8'hc0;
    localparam logic [7:0] LOSS_NONMASK    = 8'h08;

    localparam int BIAS_W = 9;

    typedef enum logic [1:0] {
        LOSS_INIT = 2'b00,
        LOSS_RUN  = 2'b01
    } loss_state_e;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_FAST = 2'b01,
        SEL_LOSS = 2'b11,
        SEL_WARN = 2'b10
    } reg_sel_e;

endpackage

// ===== rtl/loss_if.sv
// Interface between the status bank and its receive-loss hysteresis tracker.
`timescale 1ns/1ps
interface loss_if;
    logic third_monitor_input_valid;
    logic above_upper;
    logic below_lower;
    logic high_flag;
    logic low_flag;

    modport owner (
        input  third_monitor_input_valid,
        input  above_upper,
        input  below_lower,
        output high_flag,
        output low_flag
    );

    modport user (
        output third_monitor_input_valid,
        output above_upper,
        output below_lower,
        input  high_flag,
        input  low_flag
    );
endinterface

// ===== rtl/loss_hysteresis.sv
// Receive-loss high and low flags with hysteresis and reset-time evaluation.
`timescale 1ns/1ps
module loss_hysteresis (
    input wire logic clk_sys,
    input wire logic rst,
    loss_if.owner    lif
);

    alarm_status_pkg::loss_state_e state_q;
    alarm_status_pkg::loss_state_e state_d;
    logic                          high_q;
    logic                          high_d;
    logic                          low_q;
    logic                          low_d;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // The first cycle after reset samples the comparator levels whether or
    // not a fresh comparison is flagged, so the flags never start stale.
    always_comb begin
        state_d = state_q;
        high_d  = high_q;
        low_d   = low_q;
        case (state_q)
            alarm_status_pkg::LOSS_INIT: begin
                high_d  = lif.above_upper;
                low_d   = lif.below_lower;
                state_d = alarm_status_pkg::LOSS_RUN;
            end
            default: begin
                if (lif.third_monitor_input_valid) begin
                    if (lif.above_upper) begin
                        high_d = 1'b1;
                    end else if (lif.below_lower) begin
                        high_d = 1'b0;
                    end
                    if (lif.below_lower) begin
                        low_d = 1'b1;
                    end else if (lif.above_upper) begin
                        low_d = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= alarm_status_pkg::LOSS_INIT;
            high_q  <= 1'b0;
            low_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            high_q  <= high_d;
            low_q   <= low_d;
        end
    end

    assign lif.high_flag = high_q;
    assign lif.low_flag  = low_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_run_cmp;
        state_q == alarm_status_pkg::LOSS_RUN && lif.third_monitor_input_valid;
    endsequence

    AST_LOSS_HI_SET: assert property (
        s_run_cmp and lif.above_upper |=> lif.high_flag
    ) else $error("rx loss high flag did not set above upper threshold");

    AST_LOSS_HI_HOLD: assert property (
        lif.high_flag && !(lif.third_monitor_input_valid && lif.below_lower) |=> lif.high_flag
    ) else $error("rx loss high flag dropped without a low comparison");

    AST_LOSS_LO_SET: assert property (
        s_run_cmp and lif.below_lower |=> lif.low_flag
    ) else $error("rx loss low flag did not set below lower threshold");

    AST_LOSS_LO_CLR: assert property (
        s_run_cmp and lif.above_upper && !lif.below_lower |=> !lif.low_flag
    ) else $error("rx loss low flag did not clear above upper threshold");

    AST_LOSS_POR_EVAL: assert property (
        state_q == alarm_status_pkg::LOSS_INIT
        |=> lif.high_flag == $past(lif.above_upper) && lif.low_flag == $past(lif.below_lower)
    ) else $error("rx loss flags not evaluated after reset");

endmodule

// ===== sim/host_reader.sv
// Host-side model that reads the status bank through its read port.
`timescale 1ns/1ps
module host_reader (
    input  wire logic       clk_sys,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_hit
);
    initial begin
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
    end

    // The request is held for exactly one rising edge; the answer is taken one edge later.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic hit);
        @(negedge clk_sys);
        reg_rd_en = 1'b1;
        reg_addr  = addr;
        @(negedge clk_sys);
        data      = reg_rd_data;
        hit       = reg_rd_hit;
        reg_rd_en = 1'b0;
        // The address is scrambled on release so nothing can lean on a stale value.
        reg_addr  = ~addr;
    endtask
endmodule

// ===== sim/monitor_alarm_warning_status_bench.sv
// Self-checking bench for the alarm and warning status bank.
`timescale 1ns/1ps
module monitor_alarm_warning_status_bench;
    logic       clk_sys, rst, tx_disable_event, bias_cmp_valid, bias_above_threshold;
    logic       txp_cmp_valid, txp_above_high, txp_below_low, third_monitor_input_cmp_valid;
    logic       third_monitor_input_above_upper, third_monitor_input_below_lower, bias_req_valid, supply_below_poa_trip;
    logic [8:0] bias_request, bias_ceiling_setting;
    logic [3:0] meas_valid, meas_above_high, meas_below_low;
    logic [7:0] warn_enable, loss_enable, shutdown_enable, reg_addr, reg_rd_data;
    logic       reg_rd_en, reg_rd_hit, transmit_fault_interrupt, laser_shutdown_gate;
    int         checks, fails, cycles;

    monitor_alarm_warning_status u_monitor_alarm_warning_status (
        .clk_sys(clk_sys),
        .rst(rst),
        .tx_disable_event(tx_disable_event),
        .bias_cmp_valid(bias_cmp_valid),
        .bias_above_threshold(bias_above_threshold),
        .txp_cmp_valid(txp_cmp_valid),
        .txp_above_high(txp_above_high),
        .txp_below_low(txp_below_low),
        .third_monitor_input_cmp_valid(third_monitor_input_cmp_valid),
        .third_monitor_input_above_upper(third_monitor_input_above_upper),
        .third_monitor_input_below_lower(third_monitor_input_below_lower),
        .bias_req_valid(bias_req_valid),
        .bias_request(bias_request),
        .bias_ceiling_setting(bias_ceiling_setting),
        .meas_valid(meas_valid),
        .meas_above_high(meas_above_high),
        .meas_below_low(meas_below_low),
        .supply_below_poa_trip(supply_below_poa_trip),
        .warn_enable(warn_enable),
        .loss_enable(loss_enable),
        .shutdown_enable(shutdown_enable),
        .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr),
        .reg_rd_data(reg_rd_data),
        .reg_rd_hit(reg_rd_hit),
        .transmit_fault_interrupt(transmit_fault_interrupt),
        .laser_shutdown_gate(laser_shutdown_gate)
    );
    host_reader u_host_reader (.clk_sys(clk_sys), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit));

    // ****************************************************************
    // Clock, timeout and checking helpers
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bit_is(input logic got, input logic exp);
        cmp({7'h00, got}, {7'h00, exp});
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic hit_exp);
        logic [7:0] d;
        logic       h;
        u_host_reader.read_reg(addr, d, h);
        cmp(d, exp);
        bit_is(h, hit_exp);
    endtask

    // Pulses raised at a falling edge are taken at the next rising edge, then dropped.
    // One more edge passes with them low, so the next pulse is a fresh request.
    task automatic tick();
        @(negedge clk_sys);
        tx_disable_event = 1'b0;
        bias_cmp_valid   = 1'b0;
        txp_cmp_valid    = 1'b0;
        third_monitor_input_cmp_valid   = 1'b0;
        bias_req_valid   = 1'b0;
        meas_valid       = 4'h0;
        @(negedge clk_sys);
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {checks, fails} = 0;
        {tx_disable_event, bias_cmp_valid, bias_above_threshold, txp_cmp_valid} = 4'h0;
        {txp_above_high, txp_below_low, third_monitor_input_cmp_valid, third_monitor_input_above_upper} = 4'h0;
        {third_monitor_input_below_lower, bias_req_valid, supply_below_poa_trip} = 3'h0;
        bias_request         = 9'h000;
        bias_ceiling_setting = 9'h000;
        {meas_valid, meas_above_high, meas_below_low} = 12'h000;
        warn_enable     = 8'h00;
        loss_enable     = 8'h00;
        shutdown_enable = 8'h02;
        do_reset();
        rd(8'h72, 8'h00, 1'b1);
        rd(8'h73, 8'h00, 1'b1);
        rd(8'h74, 8'h10, 1'b1);
        rd(8'h75, 8'h00, 1'b0);
        rd(8'h71, 8'h00, 1'b0);
        bit_is(transmit_fault_interrupt, 1'b0);
        // Fast comparisons, then a transmit-disable event.
        txp_cmp_valid  = 1'b1;
        txp_above_high = 1'b1;
        tick();
        rd(8'h72, 8'h02, 1'b1);
        bit_is(laser_shutdown_gate, 1'b1);
        bit_is(transmit_fault_interrupt, 1'b1);
        bias_cmp_valid       = 1'b1;
        bias_above_threshold = 1'b1;
        txp_cmp_valid        = 1'b1;
        txp_above_high       = 1'b0;
        txp_below_low        = 1'b1;
        tick();
        rd(8'h72, 8'h09, 1'b1);
        bit_is(laser_shutdown_gate, 1'b0);
        tx_disable_event = 1'b1;
        tick();
        rd(8'h72, 8'h00, 1'b1);
        bit_is(transmit_fault_interrupt, 1'b0);
        // Bias ceiling: above, equal, above again, then disable.
        bias_request         = 9'h101;
        bias_ceiling_setting = 9'h100;
        bias_req_valid       = 1'b1;
        tick();
        rd(8'h73, 8'h08, 1'b1);
        bit_is(transmit_fault_interrupt, 1'b1);
        bias_request   = 9'h100;
        bias_req_valid = 1'b1;
        tick();
        rd(8'h73, 8'h00, 1'b1);
        bias_request   = 9'h1ff;
        bias_req_valid = 1'b1;
        tick();
        tx_disable_event = 1'b1;
        tick();
        rd(8'h73, 8'h00, 1'b1);
        // Loss hysteresis holds through quiet results and transmit-disable.
        third_monitor_input_cmp_valid   = 1'b1;
        third_monitor_input_above_upper = 1'b1;
        tick();
        third_monitor_input_cmp_valid   = 1'b1;
        third_monitor_input_above_upper = 1'b0;
        tick();
        tx_disable_event = 1'b1;
        tick();
        rd(8'h73, 8'h80, 1'b1);
        loss_enable = 8'h80;
        rd(8'h72, 8'h00, 1'b1);
        bit_is(transmit_fault_interrupt, 1'b1);
        loss_enable      = 8'h00;
        third_monitor_input_cmp_valid   = 1'b1;
        third_monitor_input_below_lower = 1'b1;
        tick();
        third_monitor_input_cmp_valid   = 1'b1;
        third_monitor_input_below_lower = 1'b0;
        tick();
        tx_disable_event = 1'b1;
        tick();
        rd(8'h73, 8'h40, 1'b1);
        // Reset-time evaluation of the loss flags.
        for (int i = 0; i < 2; i++) begin
            third_monitor_input_above_upper = i[0];
            third_monitor_input_below_lower = ~i[0];
            do_reset();
            rd(8'h73, i[0] ? 8'h80 : 8'h40, 1'b1);
        end
        // Warnings: supply low clears on a good reading, then each channel in turn.
        supply_below_poa_trip = 1'b0;
        meas_valid            = 4'h2;
        tick();
        rd(8'h74, 8'h00, 1'b1);
        for (int c = 0; c < 4; c++) begin
            meas_valid      = 4'hf;
            meas_above_high = 4'h1 << c;
            meas_below_low  = 4'h0;
            tick();
            rd(8'h74, 8'h80 >> (2 * c), 1'b1);
            meas_valid      = 4'hf;
            meas_above_high = 4'h0;
            meas_below_low  = 4'h1 << c;
            tick();
            rd(8'h74, 8'h40 >> (2 * c), 1'b1);
        end
        meas_below_low        = 4'h0;
        meas_valid            = 4'hf;
        supply_below_poa_trip = 1'b1;
        tick();
        warn_enable = 8'h10;
        rd(8'h74, 8'h10, 1'b1);
        bit_is(transmit_fault_interrupt, 1'b1);
        complete_run();
    end
endmodule
